// [event_interrupt_aggregator.sv]
`timescale 1ns/100ps
// Summary of operation
// - Interrupt pin is open-drain, active low, only ever pulled low.
// - Disabled event holds its pending latch at zero.
// - Enabled event sets its pending latch on every rising edge.
// - Any set pending latch pulls the shared interrupt pin low.
// - Pending latch clears on host clear write or chip-wide reset.
// - Status bit returns raw event or pending latch per readback select.
// - Chip enables at 0x01F-0x022; clear and status at 0x023-0x026; select equals enable.
// - Link and lane status returns latch when enabled, zero otherwise.
// - Link enables and status at 0x47A; clears at 0x46D-0x473.
// - At 0x47B bit 3 is enable resetting to one; bit 4 clear/status.
// - Up to 89 events monitored across the register blocks.
// - Blanking completion per dual: enable bit 5 of 0x021/0x022, status 0x025/0x026.
// - Pattern-check fails: enable bits 3-0 of 0x020, status bits 3-0 of 0x024.
`include "event_interrupt_aggregator_cfg.svh"

module event_interrupt_aggregator
    import event_interrupt_aggregator_pkg::*;
#(
    parameter int CHIP_EVENTS = `EIA_CHIP_REGS * `EIA_BYTE_BITS,
    parameter int LANE_EVENTS = `EIA_LANE_REGS * `EIA_BYTE_BITS,
    parameter int GROUP_EVENTS = `EIA_GROUP_REGS * `EIA_BYTE_BITS
) (
    // Clock and chip-wide reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire reg_addr_t i_reg_addr,
    input wire reg_byte_t i_reg_wdata,
    output reg_byte_t o_reg_rdata,
    output logic o_reg_rvalid,
    // Event sources from device logic
    input wire logic [CHIP_EVENTS-1:0] i_chip_event,
    input wire logic [GROUP_EVENTS-1:0] i_group_event,
    input wire logic i_single_event,
    // Open-drain interrupt pin
    input wire logic i_int_n_i,
    output logic o_int_n_o,
    output logic o_int_n_oe
);

    localparam int NEV = CHIP_EVENTS + GROUP_EVENTS + 1;
    localparam int SINGLE_IDX = NEV - 1;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [CHIP_EVENTS-1:0] chip_en_q;
    logic [CHIP_EVENTS-1:0] chip_en_d;
    logic [`EIA_GROUP_REGS-1:0] link_en_q;
    logic [`EIA_GROUP_REGS-1:0] link_en_d;
    logic single_en_q;
    logic single_en_d;
    reg_byte_t rdata_q;
    reg_byte_t rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic int_oe_q;
    logic int_oe_d;
    logic int_n_q;

    // Bank wiring
    logic [NEV-1:0] ev_all;
    logic [NEV-1:0] en_all;
    logic [NEV-1:0] clr_all;
    logic [NEV-1:0] sel_all;
    logic [NEV-1:0] pend_all;
    logic [NEV-1:0] stat_all;
    logic [`EIA_GROUP_REGS-1:0] group_stat;

    // Decoded write strobes
    logic wr_chip_en;
    logic wr_chip_clr;
    logic wr_group_clr;
    logic wr_link_en;
    logic wr_single;
    logic [1:0] chip_en_idx;
    logic [1:0] chip_stat_idx;
    logic [2:0] group_idx;

    // ************************************************************
    // Address decode
    // ************************************************************
    always_comb begin
        wr_chip_en = i_reg_wr && (i_reg_addr >= `EIA_ADDR_CHIP_EN)
                     && (i_reg_addr <= `EIA_ADDR_CHIP_EN_LAST);
        wr_chip_clr = i_reg_wr && (i_reg_addr >= `EIA_ADDR_CHIP_STAT)
                      && (i_reg_addr <= `EIA_ADDR_CHIP_STAT_LAST);
        wr_group_clr = i_reg_wr && (i_reg_addr >= `EIA_ADDR_LANE_CLR)
                       && (i_reg_addr <= `EIA_ADDR_GROUP_CLR_LAST);
        wr_link_en = i_reg_wr && (i_reg_addr == `EIA_ADDR_LINK_EN);
        wr_single = i_reg_wr && (i_reg_addr == `EIA_ADDR_SINGLE);
        chip_en_idx = 2'(i_reg_addr - `EIA_ADDR_CHIP_EN);
        chip_stat_idx = 2'(i_reg_addr - `EIA_ADDR_CHIP_STAT);
        group_idx = 3'(i_reg_addr - `EIA_ADDR_LANE_CLR);
    end

    // ************************************************************
    // Enable registers
    // ************************************************************
    always_comb begin
        chip_en_d = chip_en_q;
        link_en_d = link_en_q;
        single_en_d = single_en_q;
        if (wr_chip_en) begin
            // Byte 1 holds pattern-check fails, bytes 2 and 3 bit 5 blanking
            chip_en_d[chip_en_idx*`EIA_BYTE_BITS +: `EIA_BYTE_BITS] =
                i_reg_wdata;
        end
        if (wr_link_en) begin
            link_en_d = i_reg_wdata[`EIA_GROUP_REGS-1:0];
        end
        if (wr_single) begin
            single_en_d = i_reg_wdata[`EIA_SINGLE_EN_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            chip_en_q <= `EIA_CHIP_EN_RESET;
            link_en_q <= `EIA_LINK_EN_RESET;
            single_en_q <= `EIA_SINGLE_EN_RESET;
        end else begin
            chip_en_q <= chip_en_d;
            link_en_q <= link_en_d;
            single_en_q <= single_en_d;
        end
    end

    // ************************************************************
    // Event bank controls
    // ************************************************************
    always_comb begin
        ev_all = {i_single_event, i_group_event, i_chip_event};
        clr_all = '0;
        en_all = '0;
        sel_all = '1;
        en_all[CHIP_EVENTS-1:0] = chip_en_q;
        // Readback select follows enable so disabled chip events read live
        sel_all[CHIP_EVENTS-1:0] = chip_en_q;
        for (int g = 0; g < `EIA_GROUP_REGS; g++) begin
            en_all[CHIP_EVENTS + g*`EIA_BYTE_BITS +: `EIA_BYTE_BITS] =
                {`EIA_BYTE_BITS{link_en_q[g]}};
        end
        en_all[SINGLE_IDX] = single_en_q;
        if (wr_chip_clr) begin
            clr_all[chip_stat_idx*`EIA_BYTE_BITS +: `EIA_BYTE_BITS] =
                i_reg_wdata;
        end
        if (wr_group_clr) begin
            clr_all[CHIP_EVENTS + group_idx*`EIA_BYTE_BITS +: `EIA_BYTE_BITS] =
                i_reg_wdata;
        end
        clr_all[SINGLE_IDX] = wr_single && i_reg_wdata[`EIA_SINGLE_STAT_BIT];
    end

    // One bank for every event keeps the latch behaviour identical
    event_latch_bank #(
        .N(NEV)
    ) u_bank (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_event(ev_all),
        .i_enable(en_all),
        .i_clear(clr_all),
        .i_status_sel(sel_all),
        .o_pending(pend_all),
        .o_status(stat_all)
    );

    // Link status folds each clear register's latches into one bit
    genvar gg;
    generate
        for (gg = 0; gg < `EIA_GROUP_REGS; gg++) begin : g_group
            assign group_stat[gg] =
                |stat_all[CHIP_EVENTS + gg*`EIA_BYTE_BITS +: `EIA_BYTE_BITS];
        end
    endgenerate

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = i_reg_rd;
        if (i_reg_rd) begin
            rdata_d = `EIA_RDATA_RESET;
            if ((i_reg_addr >= `EIA_ADDR_CHIP_EN) && (i_reg_addr <= `EIA_ADDR_CHIP_EN_LAST)) begin
                rdata_d = chip_en_q[chip_en_idx*`EIA_BYTE_BITS +: `EIA_BYTE_BITS];
            end else if ((i_reg_addr >= `EIA_ADDR_CHIP_STAT)
                         && (i_reg_addr <= `EIA_ADDR_CHIP_STAT_LAST)) begin
                rdata_d = stat_all[chip_stat_idx*`EIA_BYTE_BITS +: `EIA_BYTE_BITS];
            end else if (i_reg_addr == `EIA_ADDR_LINK_EN) begin
                rdata_d[`EIA_GROUP_REGS-1:0] = group_stat;
            end else if (i_reg_addr == `EIA_ADDR_SINGLE) begin
                rdata_d[`EIA_SINGLE_EN_BIT] = single_en_q;
                rdata_d[`EIA_SINGLE_STAT_BIT] = stat_all[SINGLE_IDX];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rdata_q <= `EIA_RDATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ************************************************************
    // Interrupt pin
    // ************************************************************
    // The pin level is never driven high; an external pull-up does that
    always_comb begin
        int_oe_d = |pend_all;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            int_oe_q <= 1'b0;
            int_n_q <= 1'b0;
        end else begin
            int_oe_q <= int_oe_d;
            int_n_q <= 1'b0;
        end
    end

    assign o_int_n_o = int_n_q;
    assign o_int_n_oe = int_oe_q;
    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_PIN_NEVER_HIGH: assert property (
        @(posedge i_clock) o_int_n_oe |-> (o_int_n_o == 1'b0))
        else $error("interrupt pin driven high");

    AST_PENDING_PULLS_LOW: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (|pend_all) |=> o_int_n_oe)
        else $error("pending latch without pin pulled low");

    AST_IDLE_RELEASES: assert property (
        @(posedge i_clock) disable iff (i_srst)
        !(|pend_all) |=> !o_int_n_oe)
        else $error("pin pulled low with nothing pending");

    AST_CHIP_EN_WRITE: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reg_wr && i_reg_addr == `EIA_ADDR_CHIP_EN)
        |=> chip_en_q[`EIA_BYTE_BITS-1:0] == $past(i_reg_wdata))
        else $error("chip enable write not stored");

    AST_SINGLE_EN_RESET: assert property (
        @(posedge i_clock) $fell(i_srst) |-> single_en_q)
        else $error("single event enable not one after reset");

    AST_SINGLE_READ: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `EIA_ADDR_SINGLE)
        |=> o_reg_rvalid && o_reg_rdata[`EIA_SINGLE_STAT_BIT] == $past(stat_all[SINGLE_IDX]))
        else $error("single event status read wrong");

    AST_LINK_DISABLED_READS_ZERO: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `EIA_ADDR_LINK_EN && !link_en_q[0])
        |=> !o_reg_rdata[0])
        else $error("disabled link group read nonzero");

    AST_CHIP_LIVE_READ: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `EIA_ADDR_CHIP_STAT && !chip_en_q[0])
        |=> o_reg_rdata[0] == $past(i_chip_event[0]))
        else $error("disabled chip event did not read live level");

    AST_RVALID_FOLLOWS: assert property (
        @(posedge i_clock) disable iff (i_srst)
        i_reg_rd |=> o_reg_rvalid)
        else $error("read answer valid missing");

    AST_LINK_EN_WRITE: assert property (
        @(posedge i_clock) disable iff (i_srst)
        wr_link_en |=> link_en_q == $past(i_reg_wdata[`EIA_GROUP_REGS-1:0]))
        else $error("link enable write not stored");

    AST_CLEAR_ONLY_READS_ZERO: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (i_reg_rd && i_reg_addr == `EIA_ADDR_LANE_CLR) |=> o_reg_rdata == `EIA_RDATA_RESET)
        else $error("clear-only register read nonzero");

    // Event held low in the clear cycle, so no set can compete with the clear
    AST_SINGLE_CLEAR: assert property (
        @(posedge i_clock) disable iff (i_srst)
        (wr_single && i_reg_wdata[`EIA_SINGLE_STAT_BIT] && !i_single_event)
        |=> !pend_all[SINGLE_IDX])
        else $error("single event clear did not drop latch");

endmodule

// [event_interrupt_aggregator_cfg.svh]
`ifndef EVENT_INTERRUPT_AGGREGATOR_CFG_SVH
`define EVENT_INTERRUPT_AGGREGATOR_CFG_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define EIA_ADDR_CHIP_EN 12'h01F
`define EIA_ADDR_CHIP_EN_LAST 12'h022
`define EIA_ADDR_CHIP_STAT 12'h023
`define EIA_ADDR_CHIP_STAT_LAST 12'h026
`define EIA_ADDR_LANE_CLR 12'h46D
`define EIA_ADDR_LINK_CLR 12'h470
`define EIA_ADDR_GROUP_CLR_LAST 12'h473
`define EIA_ADDR_LINK_EN 12'h47A
`define EIA_ADDR_SINGLE 12'h47B

// ************************************************************
// Field positions and reset values
// ************************************************************
`define EIA_SINGLE_EN_BIT 3
`define EIA_SINGLE_STAT_BIT 4
`define EIA_CHIP_EN_RESET 32'h00000000
`define EIA_LINK_EN_RESET 7'h00
`define EIA_SINGLE_EN_RESET 1'b1
`define EIA_RDATA_RESET 8'h00

// ************************************************************
// Block sizes
// ************************************************************
`define EIA_CHIP_REGS 4
`define EIA_GROUP_REGS 7
`define EIA_LANE_REGS 3
`define EIA_BYTE_BITS 8

`endif

// [event_interrupt_aggregator_pkg.sv]
package event_interrupt_aggregator_pkg;

    typedef logic [11:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;

endpackage

// [event_interrupt_aggregator_test.sv]
`timescale 1ns/100ps
`include "event_interrupt_aggregator_cfg.svh"
module event_interrupt_aggregator_test
    import event_interrupt_aggregator_pkg::*;
;
    typedef struct packed {
        logic [1:0] idx;
        reg_byte_t en;
        reg_byte_t pulse;
        reg_byte_t live;
        reg_byte_t exp;
    } row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    reg_addr_t reg_addr = 12'h000;
    reg_byte_t reg_wdata = 8'h00;
    reg_byte_t rdata;
    logic rvalid;
    logic [31:0] chip_ev = 32'h0;
    logic [55:0] grp_ev = 56'h0;
    logic single_ev = 1'b0;
    logic other_pull = 1'b0;
    logic line;
    logic int_o;
    logic int_oe;
    logic irq_seen;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // Disabled-bit live levels kept apart from enabled bits so no stray edges
    row_t rows [4] = '{'{2'h0, 8'h30, 8'h30, 8'h00, 8'h30}, '{2'h1, 8'h20, 8'hFF, 8'h0F, 8'h2F},
                       '{2'h2, 8'h0F, 8'h05, 8'hF0, 8'hF5}, '{2'h3, 8'h00, 8'hFF, 8'hA5, 8'hA5}};

    event_interrupt_aggregator uut (
        .i_clock(clock), .i_srst(srst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_chip_event(chip_ev), .i_group_event(grp_ev),
        .i_single_event(single_ev), .i_int_n_i(line), .o_int_n_o(int_o), .o_int_n_oe(int_oe)
    );
    irq_host_model host (
        .i_int_n_o(int_o), .i_int_n_oe(int_oe), .i_other_pull(other_pull),
        .o_line(line), .o_irq_seen(irq_seen)
    );

    initial begin
        forever #4 clock = ~clock;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    // Answer stands from the taking edge and is checked half a cycle later
    task automatic rd_chk(input reg_addr_t a, input reg_byte_t e);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        check({7'h00, rvalid}, 8'h01);
        check(rdata, e);
    endtask
    task automatic pin_chk(input logic low);
        check({7'h00, line}, {7'h00, !low});
        check({7'h00, irq_seen}, {7'h00, low});
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(10);
        srst = 1'b0;
        tick(1);
        check(rdata, `EIA_RDATA_RESET);
        check({7'h00, int_oe}, 8'h00);
        rd_chk(`EIA_ADDR_SINGLE, 8'h08);
        rd_chk(12'h100, 8'h00);
        foreach (rows[i]) begin
            wr(`EIA_ADDR_CHIP_EN + 12'(rows[i].idx), rows[i].en);
            rd_chk(`EIA_ADDR_CHIP_EN + 12'(rows[i].idx), rows[i].en);
            chip_ev[rows[i].idx*8 +: 8] = rows[i].pulse;
            tick(1);
            chip_ev[rows[i].idx*8 +: 8] = rows[i].live;
            tick(3);
            rd_chk(`EIA_ADDR_CHIP_STAT + 12'(rows[i].idx), rows[i].exp);
            pin_chk((rows[i].en & rows[i].pulse) != 8'h00);
            wr(`EIA_ADDR_CHIP_STAT + 12'(rows[i].idx), 8'hFF);
            tick(2);
            rd_chk(`EIA_ADDR_CHIP_STAT + 12'(rows[i].idx), ~rows[i].en & rows[i].live);
            pin_chk(1'b0);
            wr(`EIA_ADDR_CHIP_EN + 12'(rows[i].idx), 8'h00);
            chip_ev = 32'h0;
        end
        // Disable drops the latch; held level gives no second edge
        wr(`EIA_ADDR_CHIP_EN, 8'h01);
        chip_ev[0] = 1'b1;
        tick(3);
        rd_chk(`EIA_ADDR_CHIP_STAT, 8'h01);
        wr(`EIA_ADDR_CHIP_EN, 8'h00);
        rd_chk(`EIA_ADDR_CHIP_STAT, 8'h01);
        wr(`EIA_ADDR_CHIP_EN, 8'h01);
        rd_chk(`EIA_ADDR_CHIP_STAT, 8'h00);
        pin_chk(1'b0);
        // Edge and clear in the same cycle: the edge must still latch
        chip_ev[0] = 1'b0;
        tick(2);
        reg_wr = 1'b1;
        reg_addr = `EIA_ADDR_CHIP_STAT;
        reg_wdata = 8'h01;
        chip_ev[0] = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
        rd_chk(`EIA_ADDR_CHIP_STAT, 8'h01);
        // Link and lane groups: set one event per group, clear one by one
        wr(`EIA_ADDR_LINK_EN, 8'h7F);
        for (int n = 0; n < 7; n++) begin
            grp_ev[n*9] = 1'b1;
            tick(1);
        end
        tick(2);
        rd_chk(`EIA_ADDR_LINK_EN, 8'h7F);
        for (int n = 0; n < 7; n++) begin
            wr(`EIA_ADDR_LANE_CLR + 12'(n), 8'h01 << n);
            rd_chk(`EIA_ADDR_LINK_EN, (8'hFE << n) & 8'h7F);
        end
        rd_chk(`EIA_ADDR_LANE_CLR, 8'h00);
        wr(`EIA_ADDR_LINK_EN, 8'h00);
        grp_ev = 56'h0;
        tick(1);
        grp_ev = ~56'h0;
        tick(3);
        rd_chk(`EIA_ADDR_LINK_EN, 8'h00);
        wr(`EIA_ADDR_LINK_EN, 8'h7F);
        rd_chk(`EIA_ADDR_LINK_EN, 8'h00);
        grp_ev = 56'h0;
        // Single link event serviced the way a host should
        wr(`EIA_ADDR_CHIP_STAT, 8'h01);
        wr(`EIA_ADDR_CHIP_EN, 8'h00);
        single_ev = 1'b1;
        tick(3);
        pin_chk(1'b1);
        check({7'h00, int_o}, 8'h00);
        rd_chk(`EIA_ADDR_SINGLE, 8'h18);
        wr(`EIA_ADDR_SINGLE, 8'h00);
        rd_chk(`EIA_ADDR_SINGLE, 8'h00);
        single_ev = 1'b0;
        wr(`EIA_ADDR_SINGLE, 8'h10);
        wr(`EIA_ADDR_SINGLE, 8'h08);
        rd_chk(`EIA_ADDR_SINGLE, 8'h08);
        pin_chk(1'b0);
        // A second device sinking the line while this one stays released
        other_pull = 1'b1;
        tick(1);
        pin_chk(1'b1);
        check({7'h00, int_oe}, 8'h00);
        other_pull = 1'b0;
        // Mid-run reset clears a pending latch
        wr(`EIA_ADDR_CHIP_EN, 8'h02);
        // Bit 0 is disabled and would read its live level, so drop it too
        chip_ev = 32'h00000002;
        tick(1);
        chip_ev[1] = 1'b0;
        tick(3);
        pin_chk(1'b1);
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        tick(1);
        rd_chk(`EIA_ADDR_CHIP_EN, 8'h00);
        wr(`EIA_ADDR_CHIP_EN, 8'h02);
        rd_chk(`EIA_ADDR_CHIP_STAT, 8'h00);
        pin_chk(1'b0);
        end_sim();
    end
endmodule

// [event_latch_bank.sv]
`timescale 1ns/100ps
// ************************************************************
// Pending latches for a bank of events
// ************************************************************
module event_latch_bank #(
    parameter int N = 8
) (
    // Clock and chip-wide reset
    input wire logic i_clock,
    input wire logic i_srst,
    // Event sources and controls, same clock domain
    input wire logic [N-1:0] i_event,
    input wire logic [N-1:0] i_enable,
    input wire logic [N-1:0] i_clear,
    input wire logic [N-1:0] i_status_sel,
    // Results
    output logic [N-1:0] o_pending,
    output logic [N-1:0] o_status
);

    logic [N-1:0] event_q;
    logic [N-1:0] event_d;
    logic [N-1:0] pending_q;
    logic [N-1:0] pending_d;

    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_bit
            always_comb begin
                event_d[k] = i_event[k];
                if (!i_enable[k]) begin
                    pending_d[k] = 1'b0;
                end else if (i_event[k] && !event_q[k]) begin
                    // Set beats clear so an edge in the clear cycle is kept
                    pending_d[k] = 1'b1;
                end else if (i_clear[k]) begin
                    pending_d[k] = 1'b0;
                end else begin
                    pending_d[k] = pending_q[k];
                end
            end

            always_ff @(posedge i_clock) begin
                if (i_srst) begin
                    event_q[k] <= 1'b0;
                    pending_q[k] <= 1'b0;
                end else begin
                    event_q[k] <= event_d[k];
                    pending_q[k] <= pending_d[k];
                end
            end

            // Disabled latch reads zero when selected; else the live level
            assign o_status[k] = i_status_sel[k] ? (pending_q[k] & i_enable[k])
                                                 : i_event[k];

            AST_DISABLED_ZERO: assert property (
                @(posedge i_clock) disable iff (i_srst)
                !i_enable[k] |=> !pending_q[k])
                else $error("pending latch set while disabled");

            AST_RISE_SETS: assert property (
                @(posedge i_clock) disable iff (i_srst)
                (i_enable[k] && i_event[k] && !event_q[k]) |=> pending_q[k])
                else $error("rising edge did not set pending latch");

            AST_CLEAR_DROPS: assert property (
                @(posedge i_clock) disable iff (i_srst)
                (i_clear[k] && !(i_event[k] && !event_q[k])) |=> !pending_q[k])
                else $error("clear did not drop pending latch");

            AST_HELD_LEVEL: assert property (
                @(posedge i_clock) disable iff (i_srst)
                (i_enable[k] && i_event[k] && event_q[k] && !i_clear[k]
                 && !pending_q[k]) |=> !pending_q[k])
                else $error("steady high level set latch twice");
        end
    endgenerate

    assign o_pending = pending_q;

endmodule

// [irq_host_model.sv]
`timescale 1ns/100ps
// ************************************************************
// Host side of the shared interrupt line
// ************************************************************
module irq_host_model (
    // Device pin driver
    input wire logic i_int_n_o,
    input wire logic i_int_n_oe,
    // Another open-drain device on the same line
    input wire logic i_other_pull,
    // Resolved line level and host view
    output logic o_line,
    output logic o_irq_seen
);
    // Pull-up wins unless some device sinks; a driven high is never honoured
    assign o_line = ((i_int_n_oe && (i_int_n_o == 1'b0)) || i_other_pull) ? 1'b0 : 1'b1;
    assign o_irq_seen = !o_line;
endmodule
